// File: design/mif_pkg.sv
package mif_pkg;
	// ******************************************
	// register map (printed offsets are indices)
	// ******************************************
	localparam logic [11:0] MIF_IDX_CAUSE  = 12'h004;
	localparam logic [11:0] MIF_IDX_MASK   = 12'h006;
	localparam logic [11:0] MIF_ADDR_CAUSE = 12'h010;
	localparam logic [11:0] MIF_ADDR_MASK  = 12'h018;
	localparam logic [15:0] MIF_CAUSE_RST  = 16'h0000;
	localparam logic [15:0] MIF_MASK_RST   = 16'h0000;
	localparam logic [15:0] MIF_VALID_BITS = 16'hdf07;

	// ******************************************
	// cause and enable bit positions
	// ******************************************
	localparam int MIF_B_OVERRUN  = 15;
	localparam int MIF_B_DONE     = 14;
	localparam int MIF_B_REVERSAL = 12;
	localparam int MIF_B_ZX_LOSS  = 11;
	localparam int MIF_B_LOW_V    = 10;
	localparam int MIF_B_HIGH_V   = 9;
	localparam int MIF_B_EXCESS_I = 8;
	localparam int MIF_B_WRAP     = 2;
	localparam int MIF_B_SUM      = 1;
	localparam int MIF_B_SUPPLY   = 0;

	localparam int MIF_NUM_VCH = 3;

	typedef struct packed {
		logic [15:0]            cause;
		logic [15:0]            mask;
		logic                   irq_n;
		logic [31:0]            hrdata;
		logic                   wr_pend;
		logic [11:0]            wr_addr;
		logic                   busy;
		logic                   primed;
		logic                   dir;
		logic [15:0]            chk;
		logic [MIF_NUM_VCH-1:0] uv_hold;
	} mif_state_t;
endpackage

// File: design/mif_irq_flags.sv
`timescale 1ns/10ps
// What this block does
// RQ1 - cause bits stay set until host clears them; set wins over clear
// RQ2 - bit 15 set when a new cycle starts before the last one finished
// RQ3 - host should raise the sample interval after an overrun
// RQ4 - bit 14 set whenever a computation cycle completes
// RQ5 - bit 12 set when real energy flow direction reverses
// RQ6 - bit 11 set when zero crossings are lost past the timeout
// RQ7 - bit 10 set when a voltage stays at or below limit a whole cycle
// RQ8 - bit 9 set when a voltage rises above the high limit
// RQ9 - bit 8 set when a current rises above the excess limit
// RQ10 - bit 2 set when any energy accumulator wraps out of its msb
// RQ11 - bit 1 set when the settings checksum changes value
// RQ12 - host should examine every settings checksum change
// RQ13 - bit 0 set when supply failure is imminent
// RQ14 - host should save state on a supply failure warning
// RQ15 - enable mask lets each cause bit drive the interrupt line
// RQ16 - active-low line asserts on checksum change when enable bit 1 set
// RQ17 - line asserted while any cause and enable pair set, released otherwise
// RQ18 - reserved bits 13 and 7..3 read zero and ignore writes
module mif_irq_flags
(
	// ******************************************
	// clock and reset
	// ******************************************
	input  wire logic                            hclk,
	input  wire logic                            hresetn,
	// ******************************************
	// ahb-lite slave
	// ******************************************
	input  wire logic                            hsel,
	input  wire logic [31:0]                     haddr,
	input  wire logic [1:0]                      htrans,
	input  wire logic                            hwrite,
	input  wire logic [2:0]                      hsize,
	input  wire logic [31:0]                     hwdata,
	input  wire logic                            hready,
	output logic      [31:0]                     hrdata,
	output logic                                 hreadyout,
	output logic                                 hresp,
	// ******************************************
	// measurement engine events
	// ******************************************
	input  wire logic                            cycle_start,
	input  wire logic                            cycle_done,
	input  wire logic                            energy_reverse,
	input  wire logic                            zero_cross_lost,
	input  wire logic [mif_pkg::MIF_NUM_VCH-1:0] voltage_below,
	input  wire logic                            high_voltage_over,
	input  wire logic                            excess_current_over,
	input  wire logic                            accumulator_wrap,
	input  wire logic [15:0]                     settings_checksum,
	input  wire logic                            supply_fail_warn,
	// ******************************************
	// host interrupt line
	// ******************************************
	output logic                                 irq_n
);
	import mif_pkg::*;

	mif_state_t s_q;
	mif_state_t s_d;
	logic       sel;
	logic [15:0] evt;
	logic [15:0] clr;
	logic [MIF_NUM_VCH-1:0] hold_now;

	// ******************************************
	// next state
	// ******************************************
	always_comb
	begin
		s_d      = s_q;
		evt      = 16'h0000;
		clr      = 16'h0000;
		hold_now = s_q.uv_hold & voltage_below;
		sel      = hsel & htrans[1] & hready;

		// a start that coincides with a done is a clean hand-over
		evt[MIF_B_OVERRUN] = cycle_start & s_q.busy & ~cycle_done; // [RQ2]
		evt[MIF_B_DONE]    = cycle_done; // [RQ4]
		if (cycle_start)
		begin
			s_d.busy = 1'b1;
		end
		else if (cycle_done)
		begin
			s_d.busy = 1'b0;
		end

		// first cycle after reset only learns the levels, no false change
		s_d.primed = 1'b1;
		s_d.dir    = energy_reverse;
		s_d.chk    = settings_checksum;
		evt[MIF_B_REVERSAL] = s_q.primed & (energy_reverse != s_q.dir); // [RQ5]
		evt[MIF_B_SUM]      = s_q.primed & (settings_checksum != s_q.chk); // [RQ11]

		// per channel: below the limit on every clock since the cycle began
		if (cycle_done && s_q.busy)
		begin
			evt[MIF_B_LOW_V] = |hold_now; // [RQ7]
		end
		if (cycle_start)
		begin
			s_d.uv_hold = voltage_below;
		end
		else
		begin
			s_d.uv_hold = hold_now;
		end

		evt[MIF_B_ZX_LOSS]  = zero_cross_lost; // [RQ6]
		evt[MIF_B_HIGH_V]   = high_voltage_over; // [RQ8]
		evt[MIF_B_EXCESS_I] = excess_current_over; // [RQ9]
		evt[MIF_B_WRAP]     = accumulator_wrap; // [RQ10]
		evt[MIF_B_SUPPLY]   = supply_fail_warn; // [RQ13]

		// data phase of a write: one to clear cause, plain store to mask
		if (s_q.wr_pend && s_q.wr_addr == MIF_ADDR_CAUSE)
		begin
			clr = hwdata[15:0];
		end
		if (s_q.wr_pend && s_q.wr_addr == MIF_ADDR_MASK)
		begin
			s_d.mask = hwdata[15:0] & MIF_VALID_BITS; // [RQ18]
		end
		// event in the clearing cycle survives
		s_d.cause = ((s_q.cause & ~clr) | evt) & MIF_VALID_BITS; // [RQ1] [RQ18]

		s_d.irq_n = ~|(s_d.cause & s_d.mask); // [RQ15] [RQ16] [RQ17]

		// address phase
		s_d.wr_pend = sel & hwrite;
		s_d.wr_addr = haddr[11:0];
		if (sel && !hwrite)
		begin
			if (haddr[11:0] == MIF_ADDR_CAUSE)
			begin
				s_d.hrdata = {16'h0000, s_d.cause};
			end
			else if (haddr[11:0] == MIF_ADDR_MASK)
			begin
				s_d.hrdata = {16'h0000, s_d.mask};
			end
			else
			begin
				s_d.hrdata = 32'h0000_0000;
			end
		end
	end

	// ******************************************
	// state register
	// ******************************************
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			s_q.cause   <= MIF_CAUSE_RST;
			s_q.mask    <= MIF_MASK_RST;
			s_q.irq_n   <= 1'b1;
			s_q.hrdata  <= 32'h0000_0000;
			s_q.wr_pend <= 1'b0;
			s_q.wr_addr <= 12'h000;
			s_q.busy    <= 1'b0;
			s_q.primed  <= 1'b0;
			s_q.dir     <= 1'b0;
			s_q.chk     <= 16'h0000;
			s_q.uv_hold <= '0;
		end
		else
		begin
			s_q <= s_d;
		end
	end

	// zero wait state, always okay
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = s_q.hrdata;
	assign irq_n     = s_q.irq_n;

	// ******************************************
	// checks
	// ******************************************
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	a_overrun_sets: assert property (cycle_start && s_q.busy && !cycle_done
		|=> s_q.cause[MIF_B_OVERRUN]) else $error("overrun not flagged"); // [RQ2]
	a_done_sets: assert property (cycle_done |=> s_q.cause[MIF_B_DONE])
		else $error("cycle done not flagged"); // [RQ4]
	a_reversal_sets: assert property (s_q.primed && energy_reverse != s_q.dir
		|=> s_q.cause[MIF_B_REVERSAL]) else $error("reversal not flagged"); // [RQ5]
	a_zx_sets: assert property (zero_cross_lost |=> s_q.cause[MIF_B_ZX_LOSS])
		else $error("zero cross loss not flagged"); // [RQ6]
	a_low_v_cycle: assert property (cycle_start && !s_q.busy && voltage_below[0]
		##1 (voltage_below[0] && !cycle_start && !cycle_done)[*2]
		##1 (voltage_below[0] && cycle_done && !cycle_start)
		|=> s_q.cause[MIF_B_LOW_V]) else $error("low voltage not flagged"); // [RQ7]
	a_high_v_sets: assert property (high_voltage_over |=> s_q.cause[MIF_B_HIGH_V])
		else $error("high voltage not flagged"); // [RQ8]
	a_excess_sets: assert property (excess_current_over |=> s_q.cause[MIF_B_EXCESS_I])
		else $error("excess current not flagged"); // [RQ9]
	a_wrap_sets: assert property (accumulator_wrap |=> s_q.cause[MIF_B_WRAP])
		else $error("accumulator wrap not flagged"); // [RQ10]
	a_sum_change: assert property (s_q.primed && $changed(settings_checksum)
		|=> s_q.cause[MIF_B_SUM]) else $error("checksum change not flagged"); // [RQ11]
	a_supply_sets: assert property (supply_fail_warn |=> s_q.cause[MIF_B_SUPPLY])
		else $error("supply fail not flagged"); // [RQ13]
	a_cause_sticky: assert property (!s_q.wr_pend
		|=> (s_q.cause & $past(s_q.cause)) == $past(s_q.cause))
		else $error("cause bit dropped without clear"); // [RQ1]
	a_irq_level: assert property (irq_n == !(|(s_q.cause & s_q.mask)))
		else $error("irq line disagrees with cause and mask"); // [RQ15] [RQ17]
	a_sum_irq: assert property (settings_checksum != s_q.chk && s_q.primed
		&& s_d.mask[MIF_B_SUM] |=> !irq_n) else $error("checksum irq missing"); // [RQ16]
	a_reserved_zero: assert property (((s_q.cause | s_q.mask) & ~MIF_VALID_BITS) == 16'h0000)
		else $error("reserved bit set"); // [RQ18]


	// ******************************************
	// register bus checks
	// ******************************************
	// mask store takes the data phase word, reserved bits dropped
	a_mask_store: assert property (s_q.wr_pend && s_q.wr_addr == MIF_ADDR_MASK
		|=> s_q.mask == ($past(hwdata[15:0]) & MIF_VALID_BITS))
		else $error("mask write lost"); // [RQ15] [RQ18]

	a_mask_hold: assert property (!(s_q.wr_pend && s_q.wr_addr == MIF_ADDR_MASK)
		|=> $stable(s_q.mask))
		else $error("mask changed without write"); // [RQ15]

	// a one written with no event pending must clear its bit
	a_clear_takes: assert property (s_q.wr_pend && s_q.wr_addr == MIF_ADDR_CAUSE && !(|evt)
		|=> (s_q.cause & $past(hwdata[15:0])) == 16'h0000)
		else $error("cause clear ignored"); // [RQ1]

	// event in the clearing cycle must survive the clear
	a_set_wins: assert property (s_q.wr_pend && s_q.wr_addr == MIF_ADDR_CAUSE
		|=> (s_q.cause & $past(evt)) == ($past(evt) & MIF_VALID_BITS))
		else $error("event lost to clear"); // [RQ1]

	a_read_cause: assert property (sel && !hwrite && haddr[11:0] == MIF_ADDR_CAUSE
		|=> hrdata == {16'h0000, s_q.cause})
		else $error("cause read wrong"); // [RQ1]

	a_read_mask: assert property (sel && !hwrite && haddr[11:0] == MIF_ADDR_MASK
		|=> hrdata == {16'h0000, s_q.mask})
		else $error("mask read wrong"); // [RQ15]

	a_upper_zero: assert property (hrdata[31:16] == 16'h0000)
		else $error("upper read bits set"); // [RQ18]

	// ******************************************
	// cycle tracking checks
	// ******************************************
	a_busy_track: assert property (cycle_start |=> s_q.busy)
		else $error("cycle start not tracked"); // [RQ2]

	a_done_idles: assert property (cycle_done && !cycle_start |=> !s_q.busy)
		else $error("cycle done not tracked"); // [RQ2]

	// a channel that rose above the limit mid cycle must not flag
	a_low_v_quiet: assert property (cycle_done && !(|(s_q.uv_hold & voltage_below))
		&& !s_q.cause[MIF_B_LOW_V] |=> !s_q.cause[MIF_B_LOW_V])
		else $error("low voltage flagged falsely"); // [RQ7]

	c_irq_raise: cover property (irq_n ##1 !irq_n);
	c_clear_release: cover property (s_q.wr_pend && !irq_n ##1 irq_n);
	c_overrun: cover property (cycle_start && s_q.busy && !cycle_done);
	c_set_clear_same: cover property (s_q.wr_pend && s_q.wr_addr == MIF_ADDR_CAUSE
		&& |(hwdata[15:0] & evt));
endmodule

// File: verif/mif_host.sv
`timescale 1ns/10ps
module mif_host
(
	// ********
	// bus
	// ********
	input  wire logic        hclk,
	input  wire logic        hready,
	input  wire logic [31:0] hrdata,
	output logic             hsel,
	output logic      [31:0] haddr,
	output logic      [1:0]  htrans,
	output logic             hwrite,
	output logic      [31:0] hwdata,
	output logic             timed_out
);
	initial
	begin
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hwdata = 32'h0;
		timed_out = 1'b0;
	end

	task automatic wait_rdy();
		for (int n = 0; n < 50; n++)
		begin
			@(posedge hclk);
			if (hready === 1'b1)
				return;
		end
		timed_out = 1'b1;
	endtask

	// one transfer: address phase, then the data phase drives the write word or returns the read word
	task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {20'h0, a};
		hwrite <= w;
		htrans <= 2'h2;
		wait_rdy();
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy();
		q = hrdata;
		// released data no longer shows the last word
		hwdata <= ~d;
	endtask
endmodule

// File: verif/meter_interrupt_flags_tb.sv
`timescale 1ns/10ps
module meter_interrupt_flags_tb;
	import mif_pkg::*;
	logic        hclk, hresetn, energy_reverse;
	logic [6:0]  pl;
	logic [2:0]  voltage_below;
	logic [15:0] settings_checksum;
	logic [31:0] q;
	wire         hsel, hwrite, hreadyout, hresp, irq_n, timed_out;
	wire  [31:0] haddr, hwdata, hrdata;
	wire  [1:0]  htrans;
	int          miscompares, samples_checked;
	logic [15:0] ev_bit [6] = '{16'h4000, 16'h0001, 16'h0004, 16'h0100, 16'h0200, 16'h0800};

	mif_host u_host (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
		.timed_out(timed_out));

	mif_irq_flags u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.cycle_start(pl[6]), .cycle_done(pl[0]), .energy_reverse(energy_reverse),
		.zero_cross_lost(pl[5]), .voltage_below(voltage_below),
		.high_voltage_over(pl[4]), .excess_current_over(pl[3]),
		.accumulator_wrap(pl[2]), .settings_checksum(settings_checksum),
		.supply_fail_warn(pl[1]), .irq_n(irq_n));

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic pulse(input logic [6:0] p);
		@(posedge hclk);
		pl <= p;
		@(posedge hclk);
		pl <= 7'h00;
		#1;
	endtask

	task automatic served(input logic [15:0] exp);
		u_host.xfer(MIF_ADDR_CAUSE, 1'b0, 32'h0, q);
		check("cause", q, {16'h0, exp});
		u_host.xfer(MIF_ADDR_CAUSE, 1'b1, {16'h0, exp}, q);
		u_host.xfer(MIF_ADDR_CAUSE, 1'b0, 32'h0, q);
		check("cause cleared", q, 32'h0);
		#1;
		check("irq_n released", {31'h0, irq_n}, 32'h1);
	endtask

	task automatic stop_test();
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// a hung bus wait ends the run
	always @(posedge timed_out)
	begin
		miscompares++;
		stop_test();
	end

	initial
	begin
		hclk = 1'b0;
		forever #10 hclk = ~hclk;
	end

	initial
	begin
		hresetn = 1'b0;
		pl = 7'h00;
		energy_reverse = 1'b0;
		voltage_below = 3'h0;
		settings_checksum = 16'h1234;
		miscompares = 0;
		samples_checked = 0;
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		u_host.xfer(MIF_ADDR_MASK, 1'b0, 32'h0, q);
		check("mask reset", q, {16'h0, MIF_MASK_RST});
		check("bus okay", {30'h0, hreadyout, hresp}, 32'h2);
		u_host.xfer(12'h020, 1'b1, 32'hffff, q);
		u_host.xfer(12'h020, 1'b0, 32'h0, q);
		check("unmapped", q, 32'h0);
		u_host.xfer(MIF_ADDR_MASK, 1'b1, 32'hffffffff, q);
		u_host.xfer(MIF_ADDR_MASK, 1'b0, 32'h0, q);
		check("mask", q, 32'h0000df07);
		for (int i = 0; i < 6; i++)
		begin
			pulse(7'h01 << i);
			check("irq_n", {31'h0, irq_n}, 32'h0);
			served(ev_bit[i]);
		end
		// second start with no done in between
		pulse(7'h40);
		pulse(7'h40);
		pulse(7'h01);
		served(16'hc000);
		voltage_below <= 3'h2;
		pulse(7'h40);
		repeat (3) @(posedge hclk);
		pulse(7'h01);
		voltage_below <= 3'h0;
		served(16'h4400);
		energy_reverse <= 1'b1;
		repeat (2) @(posedge hclk);
		served(16'h1000);
		u_host.xfer(MIF_ADDR_MASK, 1'b1, 32'h0002, q);
		pulse(7'h02);
		check("irq_n masked", {31'h0, irq_n}, 32'h1);
		settings_checksum <= 16'h4321;
		repeat (2) @(posedge hclk);
		#1;
		check("irq_n sum", {31'h0, irq_n}, 32'h0);
		served(16'h0003);
		stop_test();
	end
endmodule
